// ===== hdl/tmr_pkg.sv
// tmr_pkg: constants and types shared by the 8-bit timer/counter core
// assumes: single system clock domain, timer tick arrives as a one-cycle enable
package tmr_pkg;

   localparam int unsigned TMR_WIDTH = 8;

   // waveform mode codes
   typedef enum logic [2:0] {
      TMR_MODE_NORMAL    = 3'h0,
      TMR_MODE_PC_MAX    = 3'h1,
      TMR_MODE_CTC       = 3'h2,
      TMR_MODE_FAST_MAX  = 3'h3,
      TMR_MODE_RSVD4     = 3'h4,
      TMR_MODE_PC_CMPA   = 3'h5,
      TMR_MODE_RSVD6     = 3'h6,
      TMR_MODE_FAST_CMPA = 3'h7
   } tmr_mode_t;

   // compare output mode codes
   localparam logic [1:0] TMR_COM_NONE   = 2'h0;
   localparam logic [1:0] TMR_COM_TOGGLE = 2'h1;
   localparam logic [1:0] TMR_COM_CLEAR  = 2'h2;
   localparam logic [1:0] TMR_COM_SET    = 2'h3;

   // clock select value meaning no source
   localparam logic [2:0] TMR_CS_STOPPED = 3'h0;

   // fixed limits and reset values
   localparam logic [7:0] TMR_MAX       = 8'hFF;
   localparam logic [7:0] TMR_BOTTOM    = 8'h00;
   localparam logic [7:0] TMR_CNT_RST   = 8'h00;
   localparam logic [7:0] TMR_OCR_RST   = 8'h00;
   localparam logic       TMR_WAVE_RST  = 1'b0;

endpackage : tmr_pkg

// ===== hdl/tmr_compare_unit.sv
// tmr_compare_unit: one output compare channel with buffer, flag and wave state
// assumes: counter, tick, top/bottom levels and blocking come from the core
module tmr_compare_unit
   import tmr_pkg::*;
#(
   parameter int unsigned WIDTH      = TMR_WIDTH,
   parameter bit          TOGGLE_PWM = 1'b0
) (
   input  wire logic             sys_clk,
   input  wire logic             rst,
   input  wire logic             tick,
   input  wire logic [WIDTH-1:0] counterValue,
   input  wire logic [2:0]       mode,
   input  wire logic             countingDown,
   input  wire logic             atTop,
   input  wire logic             atBottom,
   input  wire logic             matchBlock,
   input  wire logic [1:0]       compareOutputMode,
   input  wire logic             forceCompareStrobe,
   input  wire logic             cmpWrite,
   input  wire logic [WIDTH-1:0] cmpWriteData,
   input  wire logic             flagClearWrite,
   input  wire logic             flagIrqAck,
   input  wire logic             portData,
   input  wire logic             portDir,
   output logic [WIDTH-1:0]      compareValue,
   output logic                  compareFlag,
   output logic                  waveState,
   output logic                  pinOut,
   output logic                  pinOutEn,
   output logic                  match
);

   logic [WIDTH-1:0] activeValue;
   logic [WIDTH-1:0] bufferValue;
   logic             isPwm;
   logic             isFast;
   logic             matchEvent;
   logic             next_waveState;

   assign isPwm  = mode[0];
   assign isFast = mode[1] & mode[0];

   // equality compare, gated by the counter-write block
   assign match      = (counterValue == activeValue) & ~matchBlock;
   assign matchEvent = tick & match;

   // cpu writes go to buffer in pwm modes, directly otherwise
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         bufferValue <= TMR_OCR_RST;
      end else if (cmpWrite) begin
         bufferValue <= cmpWriteData;
      end
   end

   // active register update point
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         activeValue <= TMR_OCR_RST;
      end else if (!isPwm && cmpWrite) begin
         activeValue <= cmpWriteData;
      end else if (!isPwm) begin
         activeValue <= bufferValue;
      end else if (tick && (isFast ? atBottom : atTop)) begin
         activeValue <= bufferValue;
      end
   end

   // reads return what the cpu last wrote
   assign compareValue = isPwm ? bufferValue : activeValue;

   // flag: set on next tick after match, set beats clear
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         compareFlag <= 1'b0;
      end else if (matchEvent) begin
         compareFlag <= 1'b1;
      end else if (flagClearWrite || flagIrqAck) begin
         compareFlag <= 1'b0;
      end
   end

   // waveform action decode, mode bits read live
   always_comb begin
      next_waveState = waveState;
      if (!isPwm) begin
         if (matchEvent || forceCompareStrobe) begin
            case (compareOutputMode)
               TMR_COM_NONE:   next_waveState = waveState;
               TMR_COM_TOGGLE: next_waveState = ~waveState;
               TMR_COM_CLEAR:  next_waveState = 1'b0;
               TMR_COM_SET:    next_waveState = 1'b1;
               default:        next_waveState = waveState;
            endcase
         end
      end else begin
         case (compareOutputMode)
            TMR_COM_TOGGLE: begin
               if (matchEvent && TOGGLE_PWM && mode[2]) begin
                  next_waveState = ~waveState;
               end
            end
            TMR_COM_CLEAR, TMR_COM_SET: begin
               if (matchEvent) begin
                  next_waveState = (compareOutputMode == TMR_COM_SET) ^ (!isFast && countingDown);
               end else if (tick && isFast && atTop) begin
                  next_waveState = (compareOutputMode == TMR_COM_CLEAR);
               end
            end
            default: next_waveState = waveState;
         endcase
      end
   end

   // internal wave state register
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         waveState <= TMR_WAVE_RST;
      end else begin
         waveState <= next_waveState;
      end
   end

   // port override: wave replaces port data, direction from port
   assign pinOut   = (compareOutputMode != TMR_COM_NONE) ? waveState : portData;
   assign pinOutEn = portDir;

endmodule : tmr_compare_unit

// ===== hdl/tmr_core.sv
// tmr_core: 8-bit timer/counter with two compare channels and port override
// assumes: timerTick is a one-cycle enable on sys_clk; cpu strobes last one cycle
//
// What this block does
// - each tick clears, increments or decrements counter per mode; otherwise it holds.
// - clock select zero means no source; counter stays stopped.
// - cpu can read and write counter at any time.
// - cpu counter write wins over clear or count in that cycle.
// - three-bit mode from two bits in control A and one in control B.
// - overflow flag set where the mode says; it can raise an interrupt.
// - comparator checks counter against both compare values; flag set next tick.
// - flag with mask enabled requests interrupt; acknowledge clears flag.
// - writing one to a flag clears it; zero leaves it.
// - pwm modes buffer compare writes; copy to active at top or bottom.
// - normal and clear-on-match modes write compare registers directly.
// - force strobe in non-pwm modes acts like a match without flag or clear.
// - counter write blocks all compare matches for next timer cycle.
// - wave state bits keep value across mode changes.
// - output mode bits act from first match after written, unbuffered.
// - reset clears each wave state to zero.
// - nonzero output mode replaces port data; direction still from port.
// - output mode zero leaves wave state unchanged on match.
// - output mode never alters counting; selects polarity or set/clear/toggle.
// - normal and clear-on-match set overflow when counter wraps to zero.
// - mode 2 clears counter on match with compare A.
// - fast pwm counts zero to top; top 255 in mode 3, compare A in 7.
// - phase correct counts up to top then down; top 255 mode 1, A mode 5.
module tmr_core
   import tmr_pkg::*;
#(
   parameter int unsigned WIDTH = TMR_WIDTH
) (
   input  wire logic             sys_clk,
   input  wire logic             rst,
   input  wire logic             timerTick,
   input  wire logic [2:0]       clockSelectField,
   input  wire logic             waveformModeLowBit,
   input  wire logic             waveformModeMidBit,
   input  wire logic             waveformModeHighBit,
   input  wire logic [1:0]       compareOutputModeA,
   input  wire logic [1:0]       compareOutputModeB,
   input  wire logic             forceCompareStrobeA,
   input  wire logic             forceCompareStrobeB,
   input  wire logic             counterWrite,
   input  wire logic [WIDTH-1:0] counterWriteData,
   input  wire logic             compareWriteA,
   input  wire logic             compareWriteB,
   input  wire logic [WIDTH-1:0] compareWriteData,
   input  wire logic             flagWrite,
   input  wire logic             flagWriteOverflow,
   input  wire logic             flagWriteA,
   input  wire logic             flagWriteB,
   input  wire logic             overflowMask,
   input  wire logic             compareMaskA,
   input  wire logic             compareMaskB,
   input  wire logic             overflowIrqAck,
   input  wire logic             compareIrqAckA,
   input  wire logic             compareIrqAckB,
   input  wire logic             portDataA,
   input  wire logic             portDirA,
   input  wire logic             portDataB,
   input  wire logic             portDirB,
   output logic [WIDTH-1:0]      counterValue,
   output logic [WIDTH-1:0]      compareValueA,
   output logic [WIDTH-1:0]      compareValueB,
   output logic                  overflowFlag,
   output logic                  compareFlagA,
   output logic                  compareFlagB,
   output logic                  overflowIrq,
   output logic                  compareIrqA,
   output logic                  compareIrqB,
   output logic                  waveStateA,
   output logic                  waveStateB,
   output logic                  waveOutputA,
   output logic                  waveOutputAEn,
   output logic                  waveOutputB,
   output logic                  waveOutputBEn
);

   logic [2:0]       waveformModeField;
   logic             tick;
   logic             countingDown;
   logic             blockPending;
   logic [WIDTH-1:0] topValue;
   logic             atTop;
   logic             atBottom;
   logic             isPwm;
   logic             isPhase;
   logic             isFast;
   logic             matchA;
   logic             matchB;
   logic             matchBlock;
   logic             setOverflow;
   logic [WIDTH-1:0] next_counterValue;
   logic             next_countingDown;

   // mode field assembled from bits of both control registers
   assign waveformModeField = {waveformModeHighBit, waveformModeMidBit, waveformModeLowBit};

   // timer clock is an enable pulse, suppressed when no source selected
   assign tick = timerTick & (clockSelectField != TMR_CS_STOPPED);

   assign isPwm   = waveformModeField[0];
   assign isPhase = waveformModeField[0] & ~waveformModeField[1];
   assign isFast  = waveformModeField[0] & waveformModeField[1];

   // top is compare A in modes with high bit set, or in clear-on-match
   assign topValue = (waveformModeField[2] || waveformModeField == TMR_MODE_CTC) ? compareValueA : TMR_MAX;
   assign atTop    = (counterValue == topValue);
   assign atBottom = (counterValue == TMR_BOTTOM);

   // block lasts until the first tick after a counter write, even when stopped
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         blockPending <= 1'b0;
      end else if (counterWrite) begin
         blockPending <= 1'b1;
      end else if (tick) begin
         blockPending <= 1'b0;
      end
   end
   assign matchBlock = blockPending;

   // counting sequence per mode
   always_comb begin
      next_counterValue = counterValue;
      next_countingDown = countingDown;
      setOverflow       = 1'b0;
      if (tick) begin
         case (waveformModeField)
            TMR_MODE_CTC: begin
               if (matchA) begin
                  next_counterValue = TMR_BOTTOM;
               end else begin
                  next_counterValue = WIDTH'(counterValue + 1'b1);
               end
               setOverflow = (counterValue == TMR_MAX);
            end
            TMR_MODE_FAST_MAX, TMR_MODE_FAST_CMPA: begin
               if (atTop) begin
                  next_counterValue = TMR_BOTTOM;
                  setOverflow       = 1'b1;
               end else begin
                  next_counterValue = WIDTH'(counterValue + 1'b1);
               end
            end
            TMR_MODE_PC_MAX, TMR_MODE_PC_CMPA: begin
               if (atTop) begin
                  next_countingDown = 1'b1;
                  next_counterValue = WIDTH'(counterValue - 1'b1);
               end else if (atBottom) begin
                  next_countingDown = 1'b0;
                  next_counterValue = WIDTH'(counterValue + 1'b1);
                  setOverflow       = countingDown;
               end else if (countingDown) begin
                  next_counterValue = WIDTH'(counterValue - 1'b1);
               end else begin
                  next_counterValue = WIDTH'(counterValue + 1'b1);
               end
            end
            default: begin
               next_counterValue = WIDTH'(counterValue + 1'b1);
               setOverflow       = (counterValue == TMR_MAX);
            end
         endcase
      end
   end

   // counter register, cpu write has priority
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         counterValue <= TMR_CNT_RST;
      end else if (counterWrite) begin
         counterValue <= counterWriteData;
      end else begin
         counterValue <= next_counterValue;
      end
   end

   // direction state for dual-slope modes
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         countingDown <= 1'b0;
      end else if (!isPhase) begin
         countingDown <= 1'b0;
      end else begin
         countingDown <= next_countingDown;
      end
   end

   // overflow flag, set wins over clear
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         overflowFlag <= 1'b0;
      end else if (setOverflow) begin
         overflowFlag <= 1'b1;
      end else if ((flagWrite && flagWriteOverflow) || overflowIrqAck) begin
         overflowFlag <= 1'b0;
      end
   end

   // interrupt requests, gated by masks
   assign overflowIrq = overflowFlag & overflowMask;
   assign compareIrqA = compareFlagA & compareMaskA;
   assign compareIrqB = compareFlagB & compareMaskB;

   // channel A, toggle allowed in pwm with high mode bit
   tmr_compare_unit #(
      .WIDTH      (WIDTH),
      .TOGGLE_PWM (1'b1)
   ) u_cmp_a (
      .sys_clk            (sys_clk),
      .rst                (rst),
      .tick               (tick),
      .counterValue       (counterValue),
      .mode               (waveformModeField),
      .countingDown       (countingDown),
      .atTop              (atTop),
      .atBottom           (atBottom),
      .matchBlock         (matchBlock),
      .compareOutputMode  (compareOutputModeA),
      .forceCompareStrobe (forceCompareStrobeA & ~isPwm),
      .cmpWrite           (compareWriteA),
      .cmpWriteData       (compareWriteData),
      .flagClearWrite     (flagWrite & flagWriteA),
      .flagIrqAck         (compareIrqAckA),
      .portData           (portDataA),
      .portDir            (portDirA),
      .compareValue       (compareValueA),
      .compareFlag        (compareFlagA),
      .waveState          (waveStateA),
      .pinOut             (waveOutputA),
      .pinOutEn           (waveOutputAEn),
      .match              (matchA)
   );

   // channel B, no pwm toggle option
   tmr_compare_unit #(
      .WIDTH      (WIDTH),
      .TOGGLE_PWM (1'b0)
   ) u_cmp_b (
      .sys_clk            (sys_clk),
      .rst                (rst),
      .tick               (tick),
      .counterValue       (counterValue),
      .mode               (waveformModeField),
      .countingDown       (countingDown),
      .atTop              (atTop),
      .atBottom           (atBottom),
      .matchBlock         (matchBlock),
      .compareOutputMode  (compareOutputModeB),
      .forceCompareStrobe (forceCompareStrobeB & ~isPwm),
      .cmpWrite           (compareWriteB),
      .cmpWriteData       (compareWriteData),
      .flagClearWrite     (flagWrite & flagWriteB),
      .flagIrqAck         (compareIrqAckB),
      .portData           (portDataB),
      .portDir            (portDirB),
      .compareValue       (compareValueB),
      .compareFlag        (compareFlagB),
      .waveState          (waveStateB),
      .pinOut             (waveOutputB),
      .pinOutEn           (waveOutputBEn),
      .match              (matchB)
   );

endmodule : tmr_core

// ===== dv/tmr_core_props.sv
// tmr_core_props: concurrent checks on the timer core ports
// assumes: one sys_clk domain, rst async active high, bound into tmr_core
module tmr_core_props
   import tmr_pkg::*;
#(
   parameter int unsigned WIDTH = TMR_WIDTH
) (
   input wire logic             sys_clk,
   input wire logic             rst,
   input wire logic             timerTick,
   input wire logic [2:0]       clockSelectField,
   input wire logic             waveformModeLowBit,
   input wire logic             waveformModeMidBit,
   input wire logic             waveformModeHighBit,
   input wire logic [1:0]       compareOutputModeA,
   input wire logic             forceCompareStrobeA,
   input wire logic             counterWrite,
   input wire logic [WIDTH-1:0] counterWriteData,
   input wire logic             flagWrite,
   input wire logic             flagWriteA,
   input wire logic             overflowMask,
   input wire logic             compareMaskA,
   input wire logic             compareIrqAckA,
   input wire logic             portDataA,
   input wire logic             portDirA,
   input wire logic [WIDTH-1:0] counterValue,
   input wire logic [WIDTH-1:0] compareValueA,
   input wire logic             overflowFlag,
   input wire logic             compareFlagA,
   input wire logic             overflowIrq,
   input wire logic             compareIrqA,
   input wire logic             waveStateA,
   input wire logic             waveOutputA,
   input wire logic             waveOutputAEn
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   logic [2:0] md;
   logic       blk;
   // mode code and pending match block after a counter write
   assign md = {waveformModeHighBit, waveformModeMidBit, waveformModeLowBit};
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) blk <= 1'b0;
      else if (counterWrite) blk <= 1'b1;
      else if (timerTick && clockSelectField != TMR_CS_STOPPED) blk <= 1'b0;
   end
   sequence s_acc;
      timerTick && clockSelectField != TMR_CS_STOPPED && !counterWrite;
   endsequence
   sequence s_hitA;
      s_acc ##0 (!blk && counterValue == compareValueA);
   endsequence
   property p_stop;
      clockSelectField == TMR_CS_STOPPED && !counterWrite |=> $stable(counterValue);
   endproperty
   a_stop: assert property (p_stop) else $error("counter moved while stopped");
   property p_wr;
      counterWrite |=> counterValue == $past(counterWriteData);
   endproperty
   a_wr: assert property (p_wr) else $error("counter write lost");
   property p_inc;
      s_acc ##0 (md == TMR_MODE_NORMAL && counterValue != TMR_MAX) |=> counterValue - $past(counterValue) == 8'h01;
   endproperty
   a_inc: assert property (p_inc) else $error("normal count step wrong");
   property p_ovf;
      s_acc ##0 (md == TMR_MODE_NORMAL && counterValue == TMR_MAX) |=> overflowFlag && counterValue == TMR_BOTTOM;
   endproperty
   a_ovf: assert property (p_ovf) else $error("wrap without overflow");
   property p_irq;
      overflowIrq == (overflowFlag && overflowMask) && compareIrqA == (compareFlagA && compareMaskA);
   endproperty
   a_irq: assert property (p_irq) else $error("irq not flag and mask");
   property p_clr;
      (compareIrqAckA || (flagWrite && flagWriteA)) && !timerTick |=> !compareFlagA;
   endproperty
   a_clr: assert property (p_clr) else $error("flag not cleared");
   property p_keep;
      flagWrite && !flagWriteA && !compareIrqAckA && compareFlagA |=> compareFlagA;
   endproperty
   a_keep: assert property (p_keep) else $error("zero write cleared flag");
   property p_flag;
      s_hitA ##0 !md[0] |=> compareFlagA;
   endproperty
   a_flag: assert property (p_flag) else $error("match did not set flag");
   property p_blk;
      s_acc ##0 (blk && !compareFlagA) |=> !compareFlagA;
   endproperty
   a_blk: assert property (p_blk) else $error("blocked match set flag");
   property p_frc;
      forceCompareStrobeA && !timerTick && !counterWrite && !compareFlagA |=> !compareFlagA && $stable(counterValue);
   endproperty
   a_frc: assert property (p_frc) else $error("force touched flag or counter");
   property p_none;
      compareOutputModeA == TMR_COM_NONE |=> $stable(waveStateA);
   endproperty
   a_none: assert property (p_none) else $error("wave changed with mode none");
   property p_tog;
      s_hitA ##0 (md == TMR_MODE_NORMAL && compareOutputModeA == TMR_COM_TOGGLE) |=> waveStateA != $past(waveStateA);
   endproperty
   a_tog: assert property (p_tog) else $error("toggle on match missing");
   property p_pin;
      waveOutputAEn == portDirA && waveOutputA == (compareOutputModeA != TMR_COM_NONE ? waveStateA : portDataA);
   endproperty
   a_pin: assert property (p_pin) else $error("pin override wrong");
endmodule : tmr_core_props

bind tmr_core tmr_core_props #(.WIDTH(WIDTH)) u_props (.*);

// ===== dv/tmr_cpu_model.sv
// tmr_cpu_model: cpu side that services interrupt requests after a latency
// assumes: irq lines are levels on sys_clk, acks are one-cycle pulses
module tmr_cpu_model #(
   parameter int LAT = 3
) (
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic overflowIrq,
   input  wire logic compareIrqA,
   input  wire logic compareIrqB,
   output logic      overflowIrqAck,
   output logic      compareIrqAckA,
   output logic      compareIrqAckB
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [2:0] irq;
   int         w;
   assign irq = {compareIrqB, compareIrqA, overflowIrq};
   // wait LAT cycles on a pending request, then acknowledge it once
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         w <= 0;
         {compareIrqAckB, compareIrqAckA, overflowIrqAck} <= 3'h0;
      end else if (irq != 3'h0 && {compareIrqAckB, compareIrqAckA, overflowIrqAck} == 3'h0 && w < LAT) begin
         w <= w + 1;
      end else if (w == LAT) begin
         w <= 0;
         {compareIrqAckB, compareIrqAckA, overflowIrqAck} <= irq;
      end else begin
         w <= 0;
         {compareIrqAckB, compareIrqAckA, overflowIrqAck} <= 3'h0;
      end
   end
endmodule : tmr_cpu_model

// ===== dv/tb.sv
// tb: directed and random checks of the timer core through its ports
// assumes: tmr_core and tmr_cpu_model compiled, checker bound by its own file
module tb
   import tmr_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [3:0] S_CNT = 4'h0, S_OVF = 4'h1, S_FA = 4'h2, S_FB = 4'h3, S_WA = 4'h4;
   localparam logic [3:0] S_WB = 4'h5, S_IRQ = 4'h6, S_POB = 4'h7, S_PEB = 4'h8, S_CMPA = 4'h9;
   logic sys_clk = 1'b0, rst = 1'b1, timerTick = 1'b0, counterWrite = 1'b0;
   logic waveformModeLowBit = 1'b0, waveformModeMidBit = 1'b0, waveformModeHighBit = 1'b0;
   logic forceCompareStrobeA = 1'b0, forceCompareStrobeB = 1'b0, compareWriteA = 1'b0, compareWriteB = 1'b0;
   logic flagWrite = 1'b0, flagWriteOverflow = 1'b0, flagWriteA = 1'b0, flagWriteB = 1'b0;
   logic overflowMask = 1'b0, compareMaskA = 1'b0, compareMaskB = 1'b0;
   logic portDataA = 1'b1, portDirA = 1'b0, portDataB = 1'b0, portDirB = 1'b0;
   logic [2:0] clockSelectField = 3'h0;
   logic [1:0] compareOutputModeA = 2'h0, compareOutputModeB = 2'h0;
   logic [7:0] counterWriteData = 8'h00, compareWriteData = 8'h00, v;
   logic [7:0] counterValue, compareValueA, compareValueB, bitv;
   logic overflowFlag, compareFlagA, compareFlagB, overflowIrq, compareIrqA, compareIrqB;
   logic waveStateA, waveStateB, waveOutputA, waveOutputAEn, waveOutputB, waveOutputBEn;
   logic overflowIrqAck, compareIrqAckA, compareIrqAckB;
   logic [11:0] expQ[$];
   logic [11:0] e;
   int err_total = 0, check_count = 0, n;
   int seed = 32'h53715CC0;
   event obs;
   tmr_core dut (.*);
   tmr_cpu_model #(.LAT(3)) cpu (.*);
   // clock
   always #5 sys_clk = ~sys_clk;
   assign bitv = {waveOutputB, overflowIrq, waveStateB, waveStateA, compareFlagB, compareFlagA, overflowFlag, waveOutputBEn};
   task cmp8(input logic [7:0] a, input logic [7:0] b);
      check_count++;
      if (a !== b) begin
         err_total++;
         $display("[FAIL] t=%0t got %h exp %h", $time, a, b);
      end
   endtask : cmp8
   task cmp1(input logic a, input logic b);
      check_count++;
      if (a !== b) begin
         err_total++;
         $display("[FAIL] t=%0t got %h exp %h", $time, a, b);
      end
   endtask : cmp1
   // monitor takes the oldest note whenever the driver marks a result
   initial forever begin
      @(obs);
      while (expQ.size() > 0) begin
         e = expQ.pop_front();
         if (e[11:8] == S_CNT) cmp8(counterValue, e[7:0]);
         else if (e[11:8] == S_CMPA) cmp8(compareValueA, e[7:0]);
         else cmp1(bitv[e[10:8]], e[0]);
      end
   end
   task results();
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : results
   task ex(input logic [3:0] s, input logic [7:0] x);
      expQ.push_back({s, x});
      ->obs;
      #0; // let the monitor compare before the driver moves any input
   endtask : ex
   task cyc();
      @(posedge sys_clk);
      #1;
   endtask : cyc
   task tk(input int k);
      repeat (k) begin
         timerTick = 1'b1;
         cyc();
         timerTick = 1'b0;
         cyc();
      end
   endtask : tk
   task wr(input logic [7:0] x);
      counterWrite = 1'b1;
      counterWriteData = x;
      cyc();
      counterWrite = 1'b0;
   endtask : wr
   task cwA(input logic [7:0] x);
      compareWriteA = 1'b1;
      compareWriteData = x;
      cyc();
      compareWriteA = 1'b0;
   endtask : cwA
   task fw(input logic o, input logic a, input logic b);
      flagWrite = 1'b1;
      {flagWriteOverflow, flagWriteA, flagWriteB} = {o, a, b};
      cyc();
      flagWrite = 1'b0;
      {flagWriteOverflow, flagWriteA, flagWriteB} = 3'h0;
      cyc();
   endtask : fw
   task md(input tmr_mode_t m);
      {waveformModeHighBit, waveformModeMidBit, waveformModeLowBit} = m;
   endtask : md
   // main sequence
   initial begin
      repeat (3) @(posedge sys_clk);
      #1;
      rst = 1'b0;
      cyc();
      ex(S_CNT, 8'h00); ex(S_WA, 8'h00); ex(S_WB, 8'h00); ex(S_OVF, 8'h00);
      tk(3); ex(S_CNT, 8'h00);
      repeat (4) begin
         v = $random(seed);
         wr(v); ex(S_CNT, v); cyc();
      end
      clockSelectField = 3'h1;
      wr(8'hFC); tk(4); ex(S_CNT, 8'h00); ex(S_OVF, 8'h01);
      overflowMask = 1'b1; cyc(); ex(S_IRQ, 8'h01);
      overflowMask = 1'b0;
      fw(1'b1, 1'b0, 1'b0); ex(S_OVF, 8'h00);
      cwA(8'h05); ex(S_CMPA, 8'h05);
      wr(8'h05); tk(1); ex(S_CNT, 8'h06); ex(S_FA, 8'h00);
      timerTick = 1'b1; wr(8'h20); timerTick = 1'b0; cyc(); ex(S_CNT, 8'h20);
      compareOutputModeA = TMR_COM_TOGGLE; cwA(8'h22);
      tk(3); ex(S_FA, 8'h01); ex(S_WA, 8'h01);
      compareMaskA = 1'b1;
      for (n = 0; n < 20 && compareFlagA !== 1'b0; n++) cyc();
      if (n == 20) begin
         err_total++;
         results();
      end
      ex(S_FA, 8'h00);
      compareMaskA = 1'b0; compareOutputModeA = TMR_COM_NONE;
      wr(8'h21); tk(3); ex(S_FA, 8'h01); ex(S_WA, 8'h01);
      fw(1'b1, 1'b0, 1'b1); ex(S_FA, 8'h01);
      fw(1'b0, 1'b1, 1'b0); ex(S_FA, 8'h00);
      compareOutputModeB = TMR_COM_SET; // set wave state before the pin is made an output
      {forceCompareStrobeA, forceCompareStrobeB} = 2'h3; cyc();
      {forceCompareStrobeA, forceCompareStrobeB} = 2'h0; cyc();
      ex(S_WB, 8'h01); ex(S_FB, 8'h00); ex(S_CNT, 8'h24);
      portDirB = 1'b1; cyc(); ex(S_POB, 8'h01); ex(S_PEB, 8'h01);
      compareOutputModeB = TMR_COM_NONE; cyc(); ex(S_POB, 8'h00);
      md(TMR_MODE_CTC); cwA(8'h03); wr(8'h00); tk(4);
      ex(S_CNT, 8'h00); ex(S_OVF, 8'h00); ex(S_WB, 8'h01);
      md(TMR_MODE_FAST_MAX); wr(8'hFE); tk(2); ex(S_CNT, 8'h00); ex(S_OVF, 8'h01);
      md(TMR_MODE_FAST_CMPA); wr(8'h01); tk(3); ex(S_CNT, 8'h00);
      md(TMR_MODE_PC_MAX); wr(8'hFE); tk(3); ex(S_CNT, 8'hFD);
      cyc();
      results();
   end
endmodule : tb
